// ---- nibble_alu_consts.vh ----
// Purpose: Shared constants for the accumulator and port instruction executor.
// Assumes: Program words are the 10-bit machine words with the extension bits removed.
// Notes: Field codes are taken from the 10-bit word, not from the 16-bit image.
`ifndef NIBBLE_ALU_CONSTS_VH
`define NIBBLE_ALU_CONSTS_VH

// ==========================================================================
// Nibble logic operations
`define ALU_AND 3'h0
`define ALU_OR 3'h1
`define ALU_XOR 3'h2
`define ALU_INC 3'h3
`define ALU_ROT 3'h4
`define ALU_LOAD 3'h5

// ==========================================================================
// Operand sources and instruction kinds
`define SRC_REG 2'h0
`define SRC_PORT 2'h1
`define SRC_IND 2'h2
`define SRC_IMM 2'h3
`define KIND_ALU 2'h0
`define KIND_OUTN 2'h1
`define KIND_OUTB 2'h2
`define KIND_ROTZ 2'h3

// ==========================================================================
// Opcode fields of the 10-bit word: bits 8-6 group, 8-5 second digit, 4-0 tail
`define GRP_AND 3'h5
`define GRP_OR 3'h6
`define GRP_XOR 3'h2
`define GRP_IN 3'h7
`define GRP_OUT 3'h2
`define N2_OUTB 4'h6
`define N2_INC 4'h4
`define N2_ROT 4'hc
`define N2_ROTZ 4'he
`define TAIL_IND 5'h10
`define TAIL_IMM 5'h11
`define TAIL_ACC 5'h13
`define TAIL_PORT 2'h3

// ==========================================================================
// Reset values and the page pair index
`define PAIR0_RST 8'hff
`define PAIR1_RST 8'h0d
`define PAIR3_RST 8'h03
`define PAIR4_RST 8'h26
`define PAGE_PAIR 2'h2

`endif

// ---- nibble_alu_port_instr_exec.v ----
// Purpose: Decode and execute accumulator and port instructions of a nibble core.
// Assumes: One word per instr_valid pulse; rom_data is valid while rom_rd is high.
// Notes: Words outside this instruction group are ignored without side effects.
`timescale 1ns/1ps
`include "nibble_alu_consts.vh"

// How it works
// - AND register: accumulator and carry from bit 3
// - Indirect AND uses page nibble plus pointer
// - AND immediate takes operand from second word
// - OR forms store OR and clear carry
// - XOR forms store XOR, carry from bits 3
// - Increment wraps, carry set on zero
// - Rotate left, carry takes old bit 3
// - Zero-guarded rotate resets chip on zero
// - Port selector picks low or high nibble
// - Only pairs 0, 1, 3, 4 decode
// - Port input loads accumulator; output writes nibble
// - Port AND, XOR carry; OR clears
// - Byte output writes whole pair from second word at once
// - Register index from low digit, two banks
// - Decoder works on stripped 10-bit words
module nibble_alu_port_instr_exec (
    input wire clk,
    input wire rst_n,
    input wire instr_valid,
    input wire [9:0] instr_word,
    input wire [7:0] rom_data,
    input wire reg_wr,
    input wire reg_wr_bank,
    input wire [3:0] reg_wr_idx,
    input wire [3:0] reg_wr_data,
    output wire [3:0] accumulator,
    output wire carry_flag,
    output wire [7:0] port_pair0,
    output wire [7:0] port_pair1,
    output wire [7:0] port_pair3,
    output wire [7:0] port_pair4,
    output wire rom_rd,
    output wire [7:0] rom_addr,
    output wire chip_reset,
    output wire opcode_expected
);

    localparam [2:0] S_FETCH = 3'b001;
    localparam [2:0] S_IMM = 3'b010;
    localparam [2:0] S_ROM = 3'b100;

    // ======================================================================
    // Decode helpers
    function [3:0] grp_op;
        input [2:0] grp;
        begin
            if (grp == `GRP_AND) begin
                grp_op = {1'b1, `ALU_AND};
            end else if (grp == `GRP_OR) begin
                grp_op = {1'b1, `ALU_OR};
            end else if (grp == `GRP_XOR) begin
                grp_op = {1'b1, `ALU_XOR};
            end else if (grp == `GRP_IN) begin
                grp_op = {1'b1, `ALU_LOAD};
            end else begin
                grp_op = 4'h0;
            end
        end
    endfunction

    // Pair 2 has no port register, so its code is refused here.
    function [2:0] pair_map;
        input [2:0] n;
        begin
            if (n == 3'h0) begin
                pair_map = 3'b100;
            end else if (n == 3'h1) begin
                pair_map = 3'b101;
            end else if (n == 3'h3) begin
                pair_map = 3'b110;
            end else if (n == 3'h4) begin
                pair_map = 3'b111;
            end else begin
                pair_map = 3'b000;
            end
        end
    endfunction

    function [3:0] pick_nibble;
        input [7:0] byte_in;
        input hi;
        begin
            pick_nibble = hi ? byte_in[7:4] : byte_in[3:0];
        end
    endfunction

    // ======================================================================
    // State
    reg [2:0] state_ff;
    reg [3:0] acc_ff;
    reg carry_ff;
    reg [7:0] pair_ff [0:3];
    reg [3:0] regs_ff [0:31];
    reg rom_rd_ff;
    reg [7:0] rom_addr_ff;
    reg chip_reset_ff;
    reg [2:0] op_ff;
    reg [1:0] kind_ff;
    reg hi_ff;
    reg [1:0] sel_ff;
    integer i;

    // ======================================================================
    // Decoder
    reg d_hit;
    reg [2:0] d_op;
    reg [1:0] d_src;
    reg [1:0] d_kind;
    reg d_hi;
    reg d_bank;
    reg [1:0] d_pair;
    reg [3:0] g;
    reg [2:0] pm;

    always @* begin
        g = grp_op(instr_word[8:6]);
        pm = pair_map(instr_word[2:0]);
        d_hit = 1'b0;
        d_op = g[2:0];
        d_src = `SRC_REG;
        d_kind = `KIND_ALU;
        d_hi = ~instr_word[5];
        d_bank = ~instr_word[5];
        d_pair = pm[1:0];
        if (instr_word[9]) begin
            if (!instr_word[4]) begin
                d_hit = g[3] && (g[2:0] != `ALU_LOAD);
            end else if (instr_word[4:0] == `TAIL_IND) begin
                d_hit = g[3] && (g[2:0] != `ALU_LOAD);
                d_src = `SRC_IND;
            end else if (instr_word[4:0] == `TAIL_IMM) begin
                d_hit = g[3] && (g[2:0] != `ALU_LOAD) && instr_word[5];
                d_src = `SRC_IMM;
            end else if (instr_word[4:0] == `TAIL_ACC) begin
                d_hit = 1'b1;
                if (instr_word[8:5] == `N2_INC) begin
                    d_op = `ALU_INC;
                end else if (instr_word[8:5] == `N2_ROT) begin
                    d_op = `ALU_ROT;
                end else if (instr_word[8:5] == `N2_ROTZ) begin
                    d_op = `ALU_ROT;
                    d_kind = `KIND_ROTZ;
                end else begin
                    d_hit = 1'b0;
                end
            end else if (instr_word[4:3] == `TAIL_PORT) begin
                d_hit = g[3] && pm[2];
                d_src = `SRC_PORT;
            end
        end else if (instr_word[4:3] == `TAIL_PORT) begin
            if (instr_word[8:6] == `GRP_OUT) begin
                d_hit = pm[2];
                d_kind = `KIND_OUTN;
            end else if (instr_word[8:5] == `N2_OUTB) begin
                d_hit = pm[2];
                d_kind = `KIND_OUTB;
                d_src = `SRC_IMM;
            end
        end
    end

    // ======================================================================
    // Operand select and logic unit
    reg [2:0] alu_op;
    reg [3:0] alu_b;
    wire [3:0] alu_res;
    wire alu_carry;

    always @* begin
        alu_op = op_ff;
        alu_b = instr_word[3:0];
        if (state_ff == S_ROM) begin
            alu_b = pick_nibble(rom_data, hi_ff);
        end else if (state_ff == S_FETCH) begin
            alu_op = d_op;
            if (d_src == `SRC_PORT) begin
                alu_b = pick_nibble(pair_ff[d_pair], d_hi);
            end else begin
                alu_b = regs_ff[{d_bank, instr_word[3:0]}];
            end
        end
    end

    nibble_logic_unit u_logic (
        .op(alu_op),
        .a(acc_ff),
        .b(alu_b),
        .res(alu_res),
        .carry_out(alu_carry)
    );

    // ======================================================================
    // Sequencer
    always @(posedge clk) begin
        if (!rst_n || (chip_reset_ff == 1'b1)) begin
            state_ff <= S_FETCH;
            acc_ff <= 4'h0;
            carry_ff <= 1'b0;
            pair_ff[0] <= `PAIR0_RST;
            pair_ff[1] <= `PAIR1_RST;
            pair_ff[2] <= `PAIR3_RST;
            pair_ff[3] <= `PAIR4_RST;
            rom_rd_ff <= 1'b0;
            rom_addr_ff <= 8'h00;
            chip_reset_ff <= 1'b0;
            op_ff <= `ALU_AND;
            kind_ff <= `KIND_ALU;
            hi_ff <= 1'b0;
            sel_ff <= 2'h0;
        end else begin
            case (state_ff)
                S_FETCH: begin
                    if (instr_valid && d_hit) begin
                        op_ff <= d_op;
                        kind_ff <= d_kind;
                        hi_ff <= d_hi;
                        sel_ff <= d_pair;
                        if (d_src == `SRC_IMM) begin
                            state_ff <= S_IMM;
                        end else if (d_src == `SRC_IND) begin
                            state_ff <= S_ROM;
                            rom_rd_ff <= 1'b1;
                            rom_addr_ff <= {pair_ff[`PAGE_PAIR][7:4], regs_ff[0]};
                        end else if (d_kind == `KIND_OUTN) begin
                            if (d_hi) begin
                                pair_ff[d_pair][7:4] <= acc_ff;
                            end else begin
                                pair_ff[d_pair][3:0] <= acc_ff;
                            end
                        end else if ((d_kind == `KIND_ROTZ) && (acc_ff == 4'h0)) begin
                            chip_reset_ff <= 1'b1;
                        end else begin
                            acc_ff <= alu_res;
                            carry_ff <= alu_carry;
                        end
                    end
                end
                S_IMM: begin
                    if (instr_valid) begin
                        state_ff <= S_FETCH;
                        if (kind_ff == `KIND_OUTB) begin
                            pair_ff[sel_ff] <= instr_word[7:0];
                        end else begin
                            acc_ff <= alu_res;
                            carry_ff <= alu_carry;
                        end
                    end
                end
                S_ROM: begin
                    state_ff <= S_FETCH;
                    rom_rd_ff <= 1'b0;
                    acc_ff <= alu_res;
                    carry_ff <= alu_carry;
                end
                default: begin
                    state_ff <= S_FETCH;
                end
            endcase
        end
    end

    // Data memory keeps its contents across the zero-guarded reset.
    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < 32; i = i + 1) begin
                regs_ff[i] <= 4'h0;
            end
        end else if (reg_wr) begin
            regs_ff[{reg_wr_bank, reg_wr_idx}] <= reg_wr_data;
        end
    end

    assign accumulator = acc_ff;
    assign carry_flag = carry_ff;
    assign port_pair0 = pair_ff[0];
    assign port_pair1 = pair_ff[1];
    assign port_pair3 = pair_ff[2];
    assign port_pair4 = pair_ff[3];
    assign rom_rd = rom_rd_ff;
    assign rom_addr = rom_addr_ff;
    assign chip_reset = chip_reset_ff;
    assign opcode_expected = state_ff[0];

endmodule // nibble_alu_port_instr_exec

// ---- nibble_exec_properties.sv ----
// Purpose: Concurrent checks on the instruction executor ports.
// Assumes: Words are 10-bit machine words.
// Notes: Register-file operands are invisible here and are left to the bench.
`timescale 1ns/1ps
// ==========================================================================
// Checker
module nibble_exec_checker (
    input logic clk,
    input logic rst_n,
    input logic instr_valid,
    input logic [9:0] instr_word,
    input logic [3:0] accumulator,
    input logic carry_flag,
    input logic [7:0] port_pair0,
    input logic [7:0] port_pair1,
    input logic [7:0] port_pair3,
    input logic [7:0] port_pair4,
    input logic rom_rd,
    input logic [7:0] rom_addr,
    input logic chip_reset,
    input logic opcode_expected
);
    logic [3:0] acc_ff;
    logic [9:0] word_ff;
    wire take = instr_valid && opcode_expected && !chip_reset;
    // Delayed copies let a check refer to the value before execution.
    always @(posedge clk) begin
        acc_ff <= accumulator;
        word_ff <= instr_word;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_INC: assert property (take && instr_word == 10'h293 |=>
        accumulator == acc_ff + 4'h1 && carry_flag == (accumulator == 4'h0))
        else $error("increment result wrong");
    AST_INC_NZ: assert property (take && instr_word == 10'h293 && accumulator != 4'hf
        |=> !carry_flag) else $error("increment carry not cleared");
    AST_ROT: assert property (take && instr_word == 10'h393 |=>
        accumulator == {acc_ff[2:0], acc_ff[3]} && carry_flag == acc_ff[3])
        else $error("rotate result wrong");
    AST_ROTZ_ZERO: assert property (take && instr_word == 10'h3d3 && accumulator == 4'h0
        |=> chip_reset) else $error("zero rotate did not reset");
    AST_ROTZ_ROT: assert property (take && instr_word == 10'h3d3 && accumulator != 4'h0
        |=> !chip_reset && accumulator == {acc_ff[2:0], acc_ff[3]})
        else $error("guarded rotate wrong");
    AST_RST_VALS: assert property (chip_reset |=> !chip_reset && accumulator == 4'h0
        && !carry_flag && port_pair0 == 8'hff && port_pair1 == 8'h0d
        && port_pair3 == 8'h03 && port_pair4 == 8'h26) else $error("reset values wrong");
    AST_ROM_PULSE: assert property ($rose(rom_rd) |-> !opcode_expected ##1
        (!rom_rd && opcode_expected)) else $error("fetch pulse wrong");
    AST_IND_ADDR: assert property (take && instr_word == 10'h350 |=>
        rom_rd && rom_addr[7:4] == port_pair3[7:4]) else $error("fetch address wrong");
    AST_IN: assert property (take && instr_word == 10'h3f8 |=>
        accumulator == port_pair0[3:0] && !carry_flag) else $error("port input wrong");
    AST_OUT_HI: assert property (take && instr_word == 10'h098 |=>
        port_pair0[7:4] == acc_ff) else $error("port nibble output wrong");
    AST_OUTB: assert property (take && instr_word == 10'h0d8 ##1 instr_valid |=>
        port_pair0 == word_ff[7:0]) else $error("byte output wrong");
    AST_PAIR2: assert property (take && instr_word == 10'h0da |=>
        opcode_expected) else $error("pair code 2 decoded");
endmodule // nibble_exec_checker

// ---- nibble_logic_unit.v ----
// Purpose: Combinational nibble arithmetic and logic with carry result.
// Assumes: Operand b is already selected by the caller.
// Notes: Carry of AND and XOR is the AND of both sign bits.
`timescale 1ns/1ps
`include "nibble_alu_consts.vh"

module nibble_logic_unit (
    input wire [2:0] op,
    input wire [3:0] a,
    input wire [3:0] b,
    output reg [3:0] res,
    output reg carry_out
);

    reg [4:0] sum;

    always @* begin
        sum = {1'b0, a} + 5'h01;
        res = a;
        carry_out = 1'b0;
        case (op)
            `ALU_AND: begin
                res = a & b;
                carry_out = a[3] & b[3];
            end
            `ALU_OR: begin
                res = a | b;
                carry_out = 1'b0;
            end
            `ALU_XOR: begin
                res = a ^ b;
                carry_out = a[3] & b[3];
            end
            `ALU_INC: begin
                res = sum[3:0];
                carry_out = (sum[3:0] == 4'h0);
            end
            `ALU_ROT: begin
                res = {a[2:0], a[3]};
                carry_out = a[3];
            end
            `ALU_LOAD: begin
                res = b;
                carry_out = 1'b0;
            end
            default: begin
                res = a;
                carry_out = 1'b0;
            end
        endcase
    end

endmodule // nibble_logic_unit

// ---- rom_model.sv ----
// Purpose: Behavioural program memory that answers indirect operand fetches.
// Assumes: Data follows rom_addr combinationally while rom_rd is high.
// Notes: Outside a fetch the bus shows the inverse, so stale data is never trusted.
`timescale 1ns/1ps
// ==========================================================================
// Program memory
module rom_model (
    input logic rom_rd,
    input logic [7:0] rom_addr,
    output logic [7:0] rom_data
);
    assign rom_data = rom_rd ? (rom_addr ^ 8'ha5) : ~(rom_addr ^ 8'ha5);
endmodule // rom_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the accumulator and port instruction executor.
// Assumes: Inputs change on the falling edge; 16-bit images are stripped here.
// Notes: Expected values are worked out from the instruction rules.
`timescale 1ns/1ps
// ==========================================================================
// Bench
module tb_top;
    logic clk, rst_n, instr_valid, reg_wr, reg_wr_bank;
    logic [9:0] instr_word;
    logic [3:0] reg_wr_idx, reg_wr_data, b, ea;
    logic [7:0] pfx [3] = '{8'hfb, 8'hfd, 8'hf5};
    logic [7:0] pv [4] = '{8'hc9, 8'h50, 8'h23, 8'h6e};
    logic [7:0] pn [4] = '{8'h0, 8'h1, 8'h3, 8'h4};
    wire [7:0] rom_data, rom_addr, port_pair0, port_pair1, port_pair3, port_pair4;
    wire [3:0] accumulator;
    wire carry_flag, rom_rd, chip_reset, opcode_expected;
    int fails, num_checks;
    nibble_alu_port_instr_exec u_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .rom_data(rom_data), .reg_wr(reg_wr),
        .reg_wr_bank(reg_wr_bank), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
        .accumulator(accumulator), .carry_flag(carry_flag), .port_pair0(port_pair0),
        .port_pair1(port_pair1), .port_pair3(port_pair3), .port_pair4(port_pair4),
        .rom_rd(rom_rd), .rom_addr(rom_addr), .chip_reset(chip_reset),
        .opcode_expected(opcode_expected));
    rom_model u_rom (.rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data));
    function automatic logic [9:0] strip(input logic [15:0] img);
        return {img[12], img[11:8], img[4], img[3:0]};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_alu(input logic [3:0] a, input logic c);
        chk("accumulator", {4'h0, a}, {4'h0, accumulator});
        chk("carry_flag", {7'h0, c}, {7'h0, carry_flag});
    endtask
    task automatic chk_pairs(input logic [31:0] e);
        chk("port_pair0", e[31:24], port_pair0);
        chk("port_pair1", e[23:16], port_pair1);
        chk("port_pair3", e[15:8], port_pair3);
        chk("port_pair4", e[7:0], port_pair4);
    endtask
    task automatic send(input logic [9:0] w);
        @(negedge clk);
        instr_valid = 1'b1;
        instr_word = w;
    endtask
    task automatic exec(input logic [15:0] img);
        send(strip(img));
    endtask
    task automatic idle;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask
    task automatic regw(input logic bk, input logic [3:0] idx, input logic [3:0] d);
        @(negedge clk);
        {reg_wr, reg_wr_bank, reg_wr_idx, reg_wr_data} = {1'b1, bk, idx, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // A full run needs about 115 cycles, so 2000 means a hang.
    initial begin
        #50000;
        fails++;
        tally_and_finish;
    end
    initial begin
        {rst_n, instr_valid, reg_wr, reg_wr_bank, instr_word, reg_wr_idx, reg_wr_data} = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk_alu(4'h0, 1'b0);
        chk_pairs(32'hff0d0326);
        chk("opcode_expected", 8'h1, {7'h0, opcode_expected});
        for (int i = 0; i < 4; i++) begin
            exec(16'he6f8 + pn[i]);
            send({2'h0, pv[i]});
            idle;
        end
        chk_pairs(32'hc950236e);
        exec(16'he6fa);
        exec(16'hfff8);
        idle;
        chk_alu(4'h9, 1'b0);
        regw(1'b0, 4'h5, 4'ha);
        regw(1'b1, 4'h5, 4'h6);
        regw(1'b0, 4'h0, 4'h7);
        for (int k = 0; k < 3; k++) begin
            for (int s = 0; s < 7; s++) begin
                exec(16'hfff8);
                case (s)
                    0: begin
                        exec({pfx[k], 8'he5});
                        b = 4'ha;
                    end
                    1: begin
                        exec({pfx[k] - 8'h1, 8'he5});
                        b = 4'h6;
                    end
                    2: begin
                        exec({pfx[k], 8'hfc});
                        b = 4'he;
                    end
                    3: begin
                        exec({pfx[k] - 8'h1, 8'hf9});
                        b = 4'h5;
                    end
                    4: begin
                        exec({pfx[k] - 8'h1, 8'hf0});
                        b = 4'h8;
                    end
                    5: begin
                        exec({pfx[k], 8'hf0});
                        b = 4'h2;
                    end
                    default: begin
                        exec({pfx[k], 8'hf1});
                        send(10'h0bb);
                        b = 4'hb;
                    end
                endcase
                idle;
                if (s == 4 || s == 5) begin
                    chk("rom_rd", 8'h1, {7'h0, rom_rd});
                    chk("rom_addr", 8'h27, rom_addr);
                    idle;
                end
                ea = k == 0 ? 4'h9 & b : k == 1 ? 4'h9 | b : 4'h9 ^ b;
                chk_alu(ea, k != 1 && b[3]);
            end
        end
        exec(16'hfffc);
        exec(16'hf4f3);
        idle;
        chk_alu(4'hf, 1'b0);
        exec(16'hf4f3);
        idle;
        chk_alu(4'h0, 1'b1);
        exec(16'hfef9);
        idle;
        chk_alu(4'h5, 1'b0);
        exec(16'hfff8);
        exec(16'hfcf3);
        exec(16'hfef3);
        idle;
        chk_alu(4'h6, 1'b0);
        exec(16'he5fb);
        exec(16'he4f8);
        idle;
        chk_pairs(32'h6950266e);
        exec(16'hfff9);
        exec(16'hfef3);
        idle;
        chk("chip_reset", 8'h1, {7'h0, chip_reset});
        idle;
        chk_alu(4'h0, 1'b0);
        chk_pairs(32'hff0d0326);
        tally_and_finish;
    end
endmodule // tb_top
bind nibble_alu_port_instr_exec nibble_exec_checker u_chk (.clk(clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .accumulator(accumulator),
    .carry_flag(carry_flag), .port_pair0(port_pair0), .port_pair1(port_pair1),
    .port_pair3(port_pair3), .port_pair4(port_pair4), .rom_rd(rom_rd),
    .rom_addr(rom_addr), .chip_reset(chip_reset), .opcode_expected(opcode_expected));
